// ==== testbench/hmm_mailbox_engine_chk.sv ====
// Port checker for the mailbox engine.
// Assumes it is bound onto hmm_mailbox_engine and sees its ports only.
`timescale 1ns/1ps
module hmm_mailbox_engine_chk (
  // Clock and reset
  input wire        clk,
  input wire        resetn,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pready,
  // DMA
  input wire        memReq,
  input wire        memWrite,
  input wire [23:0] memAddr,
  input wire [3:0]  memByteEn,
  input wire [31:0] memWdata,
  input wire        memAck,
  // Task core and target bookkeeping
  input wire        taskStart,
  input wire        taskAbort,
  input wire        tgtClaim,
  input wire        tgtAccept,
  input wire        tgtDuplicate,
  input wire [7:0]  tgtHostStatus,
  // Interrupt
  input wire        otherIrq,
  input wire        hostIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_apb_wait: assert property ($rose(psel && penable) |=> pready)
    else $error("pready not in second access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  chk_slot_align: assert property (memReq |-> memAddr[1:0] == 2'b00)
    else $error("slot access not word aligned");
  chk_req_hold: assert property (memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memByteEn)
    && $stable(memWrite) && $stable(memWdata))
    else $error("DMA request changed before answer");
  chk_payload_first: assert property (memAck && memWrite && memByteEn == 4'hE |=> memReq && memWrite
    && memByteEn == 4'h1 && memWdata[7:0] != 8'h00)
    else $error("payload not followed by nonzero code");
  chk_cmd_pulse: assert property (taskStart || taskAbort |=> !taskStart && !taskAbort)
    else $error("command pulse too long");
  chk_slot_clear: assert property (taskStart || taskAbort |-> ##[0:20]
    (memAck && memWrite && memByteEn == 4'h1 && memWdata[7:0] == 8'h00))
    else $error("request slot not cleared");
  chk_dup_status: assert property (tgtDuplicate |-> tgtHostStatus == 8'h19)
    else $error("duplicate without status 19h");
  chk_claim_answer: assert property (tgtClaim |=> tgtAccept != tgtDuplicate)
    else $error("claim not answered once");
  chk_other_irq: assert property (otherIrq ##1 otherIrq |=> hostIrq)
    else $error("other cause without host interrupt");
endmodule // hmm_mailbox_engine_chk

bind hmm_mailbox_engine hmm_mailbox_engine_chk u_chk (
  .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pready(pready),
  .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr), .memByteEn(memByteEn),
  .memWdata(memWdata), .memAck(memAck), .taskStart(taskStart), .taskAbort(taskAbort),
  .tgtClaim(tgtClaim), .tgtAccept(tgtAccept), .tgtDuplicate(tgtDuplicate),
  .tgtHostStatus(tgtHostStatus), .otherIrq(otherIrq), .hostIrq(hostIrq));

// ==== testbench/hmm_mailbox_engine_tb.sv ====
// Self-checking bench for the mailbox engine with a memory model.
// Assumes the ring at byte 40h, four slots a side.
`timescale 1ns/1ps
`include "hmm_mailbox_defs.vh"
module hmm_mailbox_engine_tb;
  reg         clk, resetn, psel, penable, pwrite, taskReady, doneValid, needValid;
  reg         needRecv, needSend, tgtClaim, tgtRelease, otherIrq, er;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rd;
  reg  [1:0]  doneKind;
  reg  [23:0] donePtr;
  reg  [2:0]  needInitiator, needLun;
  reg  [15:0] needLenHi;
  reg  [6:0]  tgtKey;
  wire [31:0] prdata, memWdata, memRdata;
  wire [23:0] memAddr, taskPtr;
  wire [3:0]  memByteEn;
  wire [7:0]  tgtHostStatus;
  wire        pready, pslverr, memReq, memWrite, memAck, taskStart, taskAbort;
  wire        doneReady, needReady, tgtAccept, tgtDuplicate, hostIrq;
  integer     errorCnt = 0, compares = 0, i;
  reg  [25:0] expQ [$];
  reg  [25:0] em;
  reg  [23:0] p [0:3];

  hmm_mailbox_engine dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .memReq(memReq),
    .memWrite(memWrite), .memAddr(memAddr), .memByteEn(memByteEn), .memWdata(memWdata), .memAck(memAck),
    .memRdata(memRdata), .taskStart(taskStart), .taskAbort(taskAbort), .taskPtr(taskPtr),
    .taskReady(taskReady), .doneValid(doneValid), .doneKind(doneKind), .donePtr(donePtr),
    .doneReady(doneReady), .needValid(needValid), .needInitiator(needInitiator), .needLun(needLun),
    .needRecv(needRecv), .needSend(needSend), .needLenHi(needLenHi), .needReady(needReady),
    .tgtClaim(tgtClaim), .tgtRelease(tgtRelease), .tgtKey(tgtKey), .tgtAccept(tgtAccept),
    .tgtDuplicate(tgtDuplicate), .tgtHostStatus(tgtHostStatus), .otherIrq(otherIrq), .hostIrq(hostIrq));
  hmm_mem_model mdl (.clk(clk), .resetn(resetn), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
    .memByteEn(memByteEn), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task chk(input [31:0] got, input [31:0] exp, input string m);
    compares++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Setup, access, then wait for pready; held until it is sampled
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task rdchk(input [7:0] a, input [31:0] x, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, x, m);
  endtask

  task settle(input integer n);
    integer k;
    for (k = 0; k < 3000 && expQ.size() != 0; k++) @(posedge clk);
    repeat (n) @(posedge clk);
    chk(expQ.size(), 0, "results missing");
  endtask

  task tgt(input c, input r);
    @(posedge clk);
    tgtClaim <= c; tgtRelease <= r;
    @(posedge clk);
    tgtClaim <= 1'b0; tgtRelease <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  function [31:0] slot(input [7:0] c, input [23:0] q);
    slot = {q[7:0], q[15:8], q[23:16], c};
  endfunction

  // Compares each command or claim answer with the oldest note
  always @(posedge clk)
    if (resetn && (taskStart || taskAbort || tgtAccept || tgtDuplicate))
    begin
      em = (expQ.size() != 0) ? expQ.pop_front() : 26'h3FFFFFF;
      if (taskStart || taskAbort) chk({taskStart, taskAbort, taskPtr}, em, "command");
      else chk({tgtDuplicate, tgtAccept, 16'h0, tgtHostStatus}, em, "claim");
    end

  task reportAndStop;
    $display("errors %0d compares %0d", errorCnt, compares);
    if (errorCnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge clk);
    errorCnt++;
    reportAndStop;
  end

  initial
  begin
    void'($urandom(32'h59f27b8b));
    {psel, penable, pwrite, doneValid, needValid, needRecv, needSend, tgtClaim, tgtRelease, otherIrq} = 10'h0;
    {paddr, pwdata, doneKind, donePtr, needInitiator, needLun, needLenHi, tgtKey} = 0;
    taskReady = 1'b1;
    // Unwritten memory would read as unknown, never as a free slot
    for (i = 0; i < 64; i++) mdl.mem[i] = 32'h0;
    resetn = 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rdchk(`HMM_ADDR_CTRL, 32'h0, "ctrl reset");
    rdchk(`HMM_ADDR_BASE, 32'h0, "base reset");
    rdchk(`HMM_ADDR_COUNT, 32'h0, "count reset");
    apb(1'b0, 8'h20, 32'h0);
    chk(er, 1'b1, "unmapped error");
    chk(rd, 32'h0, "unmapped read");
    apb(1'b1, `HMM_ADDR_BASE, 32'h40);
    apb(1'b1, `HMM_ADDR_COUNT, 32'h4);
    rdchk(`HMM_ADDR_BASE, 32'h40, "base");
    // Start, abort, unknown code, start; the unknown one gets no command
    for (i = 0; i < 4; i++) p[i] = $urandom;
    @(negedge clk);
    mdl.mem[16] = slot(8'h01, p[0]);
    mdl.mem[17] = slot(8'h02, p[1]);
    mdl.mem[18] = slot(8'h03 + $urandom % 250, p[2]);
    mdl.mem[19] = slot(8'h01, p[3]);
    expQ = '{{2'b10, p[0]}, {2'b01, p[1]}, {2'b10, p[3]}};
    apb(1'b1, `HMM_ADDR_CTRL, 32'h3);
    settle(60);
    for (i = 0; i < 4; i++) chk(mdl.mem[16+i], slot(8'h00, p[i]), "slot freed");
    chk(hostIrq, 1'b1, "host interrupt");
    rdchk(`HMM_ADDR_INTFLAG, 32'h81, "freed flag");
    // Freed flag still up: a further free leaves it alone
    @(negedge clk);
    mdl.mem[18] = slot(8'h01, p[2]);
    expQ.push_back({2'b10, p[2]});
    settle(40);
    rdchk(`HMM_ADDR_INTFLAG, 32'h81, "flag kept");
    apb(1'b1, `HMM_ADDR_INTFLAG, 32'h1);
    repeat (3) @(posedge clk);
    rdchk(`HMM_ADDR_INTFLAG, 32'h0, "flag cleared");
    // Hand-off stalled on slot 1, then slots 0 and 3 filled behind it
    otherIrq <= 1'b1;
    taskReady <= 1'b0;
    @(negedge clk);
    mdl.mem[17] = slot(8'h02, p[1]);
    repeat (60) @(negedge clk);
    mdl.mem[16] = slot(8'h01, p[0]);
    mdl.mem[19] = slot(8'h01, p[3]);
    expQ = '{{2'b01, p[1]}, {2'b10, p[3]}, {2'b10, p[0]}};
    @(posedge clk);
    taskReady <= 1'b1;
    settle(40);
    rdchk(`HMM_ADDR_INTFLAG, 32'h84, "freed deferred");
    otherIrq <= 1'b0;
    repeat (5) @(posedge clk);
    rdchk(`HMM_ADDR_INTFLAG, 32'h81, "deferred set");
    apb(1'b1, `HMM_ADDR_INTFLAG, 32'h1);
    // One completion of each kind fills the whole reply ring
    for (i = 0; i < 4; i++)
    begin
      doneKind <= i; donePtr <= p[i]; doneValid <= 1'b1;
      do @(posedge clk); while (doneReady !== 1'b1);
      doneValid <= 1'b0;
      @(posedge clk);
    end
    repeat (150) @(posedge clk);
    for (i = 0; i < 4; i++) chk(mdl.mem[20+i], slot((i == 3) ? 8'h04 : i + 1, p[i]), "reply");
    rdchk(`HMM_ADDR_INTFLAG, 32'h82, "reply flag");
    // Block request waits for a freed reply slot
    needInitiator <= $urandom; needLun <= $urandom; needRecv <= 1'b1; needLenHi <= $urandom;
    needValid <= 1'b1;
    do @(posedge clk); while (needReady !== 1'b1);
    needValid <= 1'b0;
    repeat (60) @(posedge clk);
    chk(mdl.mem[22], slot(8'h03, p[2]), "full ring kept");
    @(negedge clk);
    mdl.mem[22][7:0] = 8'h00;
    repeat (150) @(posedge clk);
    chk(mdl.mem[22], {needLenHi[7:0], needLenHi[15:8], needInitiator, 2'b10, needLun, 8'h10}, "need");
    chk(mdl.mem[20], slot(8'h01, p[0]), "other reply kept");
    // Same key twice is a duplicate until released
    tgtKey <= $urandom;
    expQ = '{{2'b01, 24'h0}, {2'b10, 24'h19}, {2'b01, 24'h0}};
    tgt(1'b1, 1'b0);
    tgt(1'b1, 1'b0);
    tgt(1'b0, 1'b1);
    tgt(1'b1, 1'b0);
    settle(5);
    reportAndStop;
  end
endmodule // hmm_mailbox_engine_tb

// ==== testbench/hmm_mem_model.sv ====
// System memory holding the slot ring, answering DMA word requests.
// Assumes requests held until memAck; the bench fills slots directly.
`timescale 1ns/1ps
module hmm_mem_model (
  // Clock and reset
  input wire        clk,
  input wire        resetn,
  // DMA slave
  input wire        memReq,
  input wire        memWrite,
  input wire [23:0] memAddr,
  input wire [3:0]  memByteEn,
  input wire [31:0] memWdata,
  output reg        memAck,
  output reg [31:0] memRdata
);
  reg [31:0] mem [0:63];
  reg [1:0]  waitR;
  integer    i;

  always @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      memAck   <= 1'b0;
      waitR    <= 2'h0;
      memRdata <= 32'h0;
    end
    else
    begin
      // Read data is not held once answered
      memRdata <= ~memRdata;
      if (memAck)
        memAck <= 1'b0;
      else if (memReq && waitR != 2'h0)
        waitR <= waitR - 2'h1;
      else if (memReq)
      begin
        memAck <= 1'b1;
        waitR  <= $urandom % 4;
        if (memWrite)
        begin
          for (i = 0; i < 4; i++)
            if (memByteEn[i]) mem[memAddr[7:2]][8*i+:8] <= memWdata[8*i+:8];
        end
        else
          memRdata <= mem[memAddr[7:2]];
      end
    end
endmodule // hmm_mem_model

// ==== verilog/hmm_mailbox_defs.vh ====
// Constants for the host memory mailbox engine: register map, field layout,
// slot codes and reset values. Definitions only; included by the engine.
`ifndef HMM_MAILBOX_DEFS_VH
`define HMM_MAILBOX_DEFS_VH

// Register byte addresses
`define HMM_ADDR_CTRL      8'h00
`define HMM_ADDR_BASE      8'h04
`define HMM_ADDR_COUNT     8'h08
`define HMM_ADDR_INTFLAG   8'h0C
`define HMM_ADDR_STATE     8'h10

// Control fields
`define HMM_CTRL_RUN       0
`define HMM_CTRL_FREEDEN   1
// Interrupt flag fields
`define HMM_INT_FREED      0
`define HMM_INT_REPLY      1
`define HMM_INT_OTHER      2
`define HMM_INT_ANY        7

// Reset values
`define HMM_RST_BASE       24'h000000
`define HMM_RST_COUNT      8'h00

// Slot geometry
`define HMM_SLOT_BYTES     24'h000004
`define HMM_SLOT_SHIFT     2

// Byte enables: lane 0 is slot byte 0 (code), lanes 1..3 the payload
`define HMM_BE_CODE        4'h1
`define HMM_BE_PAYLOAD     4'hE

// Request slot codes
`define HMM_RQ_FREE        8'h00
`define HMM_RQ_START       8'h01
`define HMM_RQ_ABORT       8'h02

// Reply slot codes
`define HMM_RP_FREE        8'h00
`define HMM_RP_DONE_OK     8'h01
`define HMM_RP_ABORTED     8'h02
`define HMM_RP_NOT_FOUND   8'h03
`define HMM_RP_DONE_ERR    8'h04
`define HMM_RP_NEED_BLOCK  8'h10

// Host status for a duplicate target-role block
`define HMM_HS_DUPLICATE   8'h19

// Reply kinds from the task core
`define HMM_KIND_OK        2'h0
`define HMM_KIND_ABORTED   2'h1
`define HMM_KIND_NOTFOUND  2'h2
`define HMM_KIND_ERR       2'h3

`endif

// ==== verilog/hmm_mailbox_engine.v ====
// Mailbox engine: request and reply slot ring in system memory, over DMA.
// Assumes a word-wide DMA master port (byte 0 of a slot in lane 0), an APB
// master for the registers, and a task core that runs the referenced blocks.
//
// Overview of operation
// [RULE_01] Every slot is exactly four bytes
// [RULE_02] Equal slot counts, replies follow requests
// [RULE_03] Slot address from base, count, index
// [RULE_04] Initiator and target work share one ring
// [RULE_05] Request: code byte 0, pointer MSB first
// [RULE_06] Zero code byte means request slot free
// [RULE_07] Clear request code after reading slot
// [RULE_08] Code 01h starts, 02h aborts block
// [RULE_09] Other nonzero codes cleared, ignored, unanswered
// [RULE_10] Round-robin polling from slot after last
// [RULE_11] One target block per key; duplicates 19h
// [RULE_12] Missing target block requested through reply
// [RULE_13] Freed slot sets freed and any flags
// [RULE_14] Freed flag already set: leave unchanged
// [RULE_15] Other pending causes defer the freed flag
// [RULE_16] Reply: status byte 0, payload bytes 1-3
// [RULE_17] Write reply only while status is zero
// [RULE_18] Scan reply status bytes for free slot
// [RULE_19] Reply codes 01h, 02h, 04h with address
// [RULE_20] Abort miss posts 03h with supposed address
// [RULE_21] Block request uses 10h with parameters
// [RULE_22] Stored reply sets reply and any flags
// [RULE_23] Payload bytes written before code byte
`timescale 1ns/1ps
`include "hmm_mailbox_defs.vh"

module hmm_mailbox_engine (
  // Clock and reset
  input  wire        clk,
  input  wire        resetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // DMA master to system memory
  output reg         memReq,
  output reg         memWrite,
  output reg  [23:0] memAddr,
  output reg  [3:0]  memByteEn,
  output reg  [31:0] memWdata,
  input  wire        memAck,
  input  wire [31:0] memRdata,
  // Commands to the task core
  output reg         taskStart,
  output reg         taskAbort,
  output reg  [23:0] taskPtr,
  input  wire        taskReady,
  // Completions from the task core
  input  wire        doneValid,
  input  wire [1:0]  doneKind,
  input  wire [23:0] donePtr,
  output reg         doneReady,
  // Target-role request for a missing block
  input  wire        needValid,
  input  wire [2:0]  needInitiator,
  input  wire [2:0]  needLun,
  input  wire        needRecv,
  input  wire        needSend,
  input  wire [15:0] needLenHi,
  output reg         needReady,
  // Target-role block bookkeeping
  input  wire        tgtClaim,
  input  wire        tgtRelease,
  input  wire [6:0]  tgtKey,
  output reg         tgtAccept,
  output reg         tgtDuplicate,
  output reg  [7:0]  tgtHostStatus,
  // Host interrupt
  input  wire        otherIrq,
  output reg         hostIrq
);

  localparam [2:0] ST_IDLE    = 3'd0;
  localparam [2:0] ST_RQREAD  = 3'd1;
  localparam [2:0] ST_RQHAND  = 3'd2;
  localparam [2:0] ST_RQCLEAR = 3'd3;
  localparam [2:0] ST_RPREAD  = 3'd4;
  localparam [2:0] ST_RPPAY   = 3'd5;
  localparam [2:0] ST_RPCODE  = 3'd6;

  // Request slot i at base + 4i, reply slot i at base + 4*count + 4i
  function [23:0] slotAddr;
    input [23:0] base;
    input [7:0]  count;
    input        isReply;
    input [7:0]  idx;
    reg   [23:0] off;
    begin
      off = ({16'h0000, idx} << `HMM_SLOT_SHIFT);
      if (isReply)
        off = off + ({16'h0000, count} << `HMM_SLOT_SHIFT); // RULE_02
      slotAddr = base + off; // RULE_03
    end
  endfunction

  function [7:0] nextIdx;
    input [7:0] idx;
    input [7:0] count;
    begin
      if (idx + 8'h01 >= count)
        nextIdx = 8'h00;
      else
        nextIdx = idx + 8'h01;
    end
  endfunction

  function [7:0] kindCode;
    input [1:0] kind;
    begin
      case (kind)
        `HMM_KIND_OK:       kindCode = `HMM_RP_DONE_OK; // RULE_19
        `HMM_KIND_ABORTED:  kindCode = `HMM_RP_ABORTED;
        `HMM_KIND_NOTFOUND: kindCode = `HMM_RP_NOT_FOUND; // RULE_20
        default:            kindCode = `HMM_RP_DONE_ERR;
      endcase
    end
  endfunction

  // Registers
  reg         run_r;
  reg         freedEn_r;
  reg  [23:0] base_r;
  reg  [7:0]  count_r;
  reg         flagFreed_r;
  reg         flagReply_r;
  reg         deferFreed_r;
  reg         deferReply_r;
  reg  [2:0]  state_r;
  reg  [7:0]  rqIdx_r;
  reg  [7:0]  rpIdx_r;
  reg  [7:0]  rpTried_r;
  reg  [7:0]  rqCode_r;
  reg         rpHeld_r;
  reg  [7:0]  rpCode_r;
  reg  [23:0] rpData_r;
  reg  [127:0] tgtBusy_r;
  reg         evFreed;
  reg         evReply;

  wire apbAccess = psel & penable & pready;
  wire apbWrite  = apbAccess & pwrite;
  wire apbRead   = apbAccess & ~pwrite;
  wire mapped    = (paddr == `HMM_ADDR_CTRL) | (paddr == `HMM_ADDR_BASE) |
                   (paddr == `HMM_ADDR_COUNT) | (paddr == `HMM_ADDR_INTFLAG) |
                   (paddr == `HMM_ADDR_STATE);
  wire clrFreed  = apbWrite & (paddr == `HMM_ADDR_INTFLAG) & pwdata[`HMM_INT_FREED];
  wire clrReply  = apbWrite & (paddr == `HMM_ADDR_INTFLAG) & pwdata[`HMM_INT_REPLY];
  wire anyFlag   = flagFreed_r | flagReply_r | otherIrq;
  wire ringOn    = run_r & (count_r != `HMM_RST_COUNT);

  // APB slave: one wait state, answer registered
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel & penable & ~pready & ~pwrite)
      begin
        case (paddr)
          `HMM_ADDR_CTRL:    prdata <= {30'h00000000, freedEn_r, run_r};
          `HMM_ADDR_BASE:    prdata <= {8'h00, base_r};
          `HMM_ADDR_COUNT:   prdata <= {24'h000000, count_r};
          `HMM_ADDR_INTFLAG: prdata <= {24'h000000, hostIrq, 4'h0, otherIrq, flagReply_r, flagFreed_r};
          `HMM_ADDR_STATE:   prdata <= {10'h000, rpHeld_r, 2'h0, state_r, rpIdx_r, rqIdx_r};
          default:           prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Configuration writes take effect at the completing edge
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      run_r     <= 1'b0;
      freedEn_r <= 1'b0;
      base_r    <= `HMM_RST_BASE;
      count_r   <= `HMM_RST_COUNT;
    end
    else if (apbWrite)
    begin
      case (paddr)
        `HMM_ADDR_CTRL:
        begin
          run_r     <= pwdata[`HMM_CTRL_RUN];
          freedEn_r <= pwdata[`HMM_CTRL_FREEDEN];
        end
        `HMM_ADDR_BASE:  base_r  <= pwdata[23:0];
        `HMM_ADDR_COUNT: count_r <= pwdata[7:0];
        default:         run_r   <= run_r;
      endcase
    end
  end

  // Interrupt flags: a set on the clearing edge wins over the clear.
  // Deferred events wait until every other cause is gone, so clearing one
  // cause can never swallow a notice for another.
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      flagFreed_r  <= 1'b0;
      flagReply_r  <= 1'b0;
      deferFreed_r <= 1'b0;
      deferReply_r <= 1'b0;
      hostIrq      <= 1'b0;
    end
    else
    begin
      if (flagReply_r & ~clrReply)
        deferReply_r <= 1'b0;
      else if (evReply | deferReply_r)
      begin
        if (flagFreed_r | otherIrq)
        begin
          // A clear on the deferring edge must not be lost
          deferReply_r <= 1'b1; // RULE_22
          if (clrReply)
            flagReply_r <= 1'b0;
        end
        else
        begin
          flagReply_r  <= 1'b1; // RULE_22
          deferReply_r <= 1'b0;
        end
      end
      else if (clrReply)
        flagReply_r <= 1'b0;
      if (flagFreed_r & ~clrFreed)
        deferFreed_r <= 1'b0; // RULE_14
      else if (evFreed | deferFreed_r)
      begin
        if (flagReply_r | otherIrq | evReply | deferReply_r)
        begin
          deferFreed_r <= 1'b1; // RULE_15
          if (clrFreed)
            flagFreed_r <= 1'b0;
        end
        else
        begin
          flagFreed_r  <= 1'b1; // RULE_13
          deferFreed_r <= 1'b0;
        end
      end
      else if (clrFreed)
        flagFreed_r <= 1'b0;
      hostIrq <= anyFlag;
    end
  end

  // Target-role block table: one per initiator, unit and direction
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tgtBusy_r     <= 128'h0;
      tgtAccept     <= 1'b0;
      tgtDuplicate  <= 1'b0;
      tgtHostStatus <= 8'h00;
    end
    else
    begin
      tgtAccept    <= tgtClaim & ~tgtBusy_r[tgtKey];
      tgtDuplicate <= tgtClaim & tgtBusy_r[tgtKey]; // RULE_11
      if (tgtClaim & tgtBusy_r[tgtKey])
        tgtHostStatus <= `HMM_HS_DUPLICATE; // RULE_11
      else if (tgtClaim)
        tgtHostStatus <= 8'h00;
      if (tgtClaim)
        tgtBusy_r[tgtKey] <= 1'b1;
      else if (tgtRelease)
        tgtBusy_r[tgtKey] <= 1'b0;
    end
  end

  // Reply holding register; ready is low while a reply waits for a slot
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rpHeld_r  <= 1'b0;
      rpCode_r  <= `HMM_RP_FREE;
      rpData_r  <= 24'h000000;
      doneReady <= 1'b0;
      needReady <= 1'b0;
    end
    else
    begin
      if (!rpHeld_r & doneValid & doneReady)
      begin
        rpHeld_r <= 1'b1;
        rpCode_r <= kindCode(doneKind);
        rpData_r <= donePtr; // RULE_19
      end
      else if (!rpHeld_r & needValid & needReady)
      begin
        rpHeld_r <= 1'b1;
        rpCode_r <= `HMM_RP_NEED_BLOCK; // RULE_12
        rpData_r <= {needInitiator, needRecv, needSend, needLun, needLenHi}; // RULE_21
      end
      else if (state_r == ST_RPCODE && memAck)
        rpHeld_r <= 1'b0;
      doneReady <= ~rpHeld_r & ~(doneValid & doneReady) & ~(needValid & needReady);
      needReady <= ~rpHeld_r & ~doneValid & ~(doneValid & doneReady) & ~(needValid & needReady);
    end
  end

  // Slot engine: replies first, then one request slot per poll
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r   <= ST_IDLE;
      rqIdx_r   <= 8'h00;
      rpIdx_r   <= 8'h00;
      rpTried_r <= 8'h00;
      rqCode_r  <= `HMM_RQ_FREE;
      memReq    <= 1'b0;
      memWrite  <= 1'b0;
      memAddr   <= 24'h000000;
      memByteEn <= 4'h0;
      memWdata  <= 32'h00000000;
      taskStart <= 1'b0;
      taskAbort <= 1'b0;
      taskPtr   <= 24'h000000;
      evFreed   <= 1'b0;
      evReply   <= 1'b0;
    end
    else
    begin
      taskStart <= 1'b0;
      taskAbort <= 1'b0;
      evFreed   <= 1'b0;
      evReply   <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          if (ringOn && rpHeld_r && rpTried_r < count_r)
          begin
            state_r   <= ST_RPREAD;
            memReq    <= 1'b1;
            memWrite  <= 1'b0;
            memByteEn <= `HMM_BE_CODE;
            memAddr   <= slotAddr(base_r, count_r, 1'b1, rpIdx_r); // RULE_18
          end
          else if (ringOn)
          begin
            rpTried_r <= 8'h00;
            state_r   <= ST_RQREAD;
            memReq    <= 1'b1;
            memWrite  <= 1'b0;
            memByteEn <= `HMM_BE_CODE | `HMM_BE_PAYLOAD; // RULE_01
            memAddr   <= slotAddr(base_r, count_r, 1'b0, rqIdx_r); // RULE_10
          end
        end
        ST_RQREAD:
        begin
          if (memAck)
          begin
            memReq   <= 1'b0;
            rqCode_r <= memRdata[7:0]; // RULE_05
            taskPtr  <= {memRdata[15:8], memRdata[23:16], memRdata[31:24]}; // RULE_05
            if (memRdata[7:0] == `HMM_RQ_FREE)
            begin
              rqIdx_r <= nextIdx(rqIdx_r, count_r); // RULE_06
              state_r <= ST_IDLE;
            end
            else
              state_r <= ST_RQHAND;
          end
        end
        ST_RQHAND:
        begin
          // Same hand-off for initiator and target blocks
          if (rqCode_r != `HMM_RQ_START && rqCode_r != `HMM_RQ_ABORT)
            state_r <= ST_RQCLEAR; // RULE_09
          else if (taskReady)
          begin
            taskStart <= (rqCode_r == `HMM_RQ_START); // RULE_08
            taskAbort <= (rqCode_r == `HMM_RQ_ABORT); // RULE_04
            state_r   <= ST_RQCLEAR;
          end
          if (rqCode_r != `HMM_RQ_START && rqCode_r != `HMM_RQ_ABORT || taskReady)
          begin
            memReq    <= 1'b1;
            memWrite  <= 1'b1;
            memByteEn <= `HMM_BE_CODE;
            memWdata  <= {24'h000000, `HMM_RQ_FREE}; // RULE_07
          end
        end
        ST_RQCLEAR:
        begin
          if (memAck)
          begin
            memReq   <= 1'b0;
            memWrite <= 1'b0;
            evFreed  <= freedEn_r; // RULE_13
            rqIdx_r  <= nextIdx(rqIdx_r, count_r); // RULE_10
            state_r  <= ST_IDLE;
          end
        end
        ST_RPREAD:
        begin
          if (memAck)
          begin
            if (memRdata[7:0] == `HMM_RP_FREE)
            begin
              // Payload first so the host never sees a code with old data
              memWrite  <= 1'b1;
              memByteEn <= `HMM_BE_PAYLOAD; // RULE_23
              memWdata  <= {rpData_r[7:0], rpData_r[15:8], rpData_r[23:16], 8'h00}; // RULE_16
              state_r   <= ST_RPPAY; // RULE_17
            end
            else
            begin
              // Full ring: fall back to request polling after count_r failed tries
              memReq    <= 1'b0;
              rpIdx_r   <= nextIdx(rpIdx_r, count_r);
              rpTried_r <= rpTried_r + 8'h01;
              state_r   <= ST_IDLE;
            end
          end
        end
        ST_RPPAY:
        begin
          if (memAck)
          begin
            memByteEn <= `HMM_BE_CODE;
            memWdata  <= {24'h000000, rpCode_r}; // RULE_23
            state_r   <= ST_RPCODE;
          end
        end
        ST_RPCODE:
        begin
          if (memAck)
          begin
            memReq    <= 1'b0;
            memWrite  <= 1'b0;
            evReply   <= 1'b1; // RULE_22
            rpIdx_r   <= nextIdx(rpIdx_r, count_r);
            rpTried_r <= 8'h00;
            state_r   <= ST_IDLE;
          end
        end
        default:
        begin
          memReq  <= 1'b0;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // hmm_mailbox_engine
